// *** shared/nvr_params.svh ***
`ifndef NVR_PARAMS_SVH
`define NVR_PARAMS_SVH
`define NVR_CLK_PERIOD_NS 50
`define NVR_SEC_NS 1000000000
`define NVR_TEST_HZ 512
`define NVR_SEC_CYCLES (`NVR_SEC_NS / `NVR_CLK_PERIOD_NS)
`define NVR_HALF_CYCLES (`NVR_SEC_NS / (2 * `NVR_TEST_HZ * `NVR_CLK_PERIOD_NS))
`define NVR_CLK_BASE 19'h7fff8
`define NVR_IX_CEN 3'h0
`define NVR_IX_SEC 3'h1
`define NVR_IX_MIN 3'h2
`define NVR_IX_HOUR 3'h3
`define NVR_IX_DAY 3'h4
`define NVR_IX_DATE 3'h5
`define NVR_IX_MON 3'h6
`define NVR_IX_YEAR 3'h7
`define NVR_WHOLD_BIT 7
`define NVR_RHOLD_BIT 6
`define NVR_OSC_BIT 7
`define NVR_FT_BIT 6
`define NVR_MASK_CEN 8'h3f
`define NVR_MASK_SEC 8'h7f
`define NVR_MASK_MIN 8'h7f
`define NVR_MASK_HOUR 8'h3f
`define NVR_MASK_DAY 8'h07
`define NVR_MASK_DATE 8'h3f
`define NVR_MASK_MON 8'h1f
`define NVR_MASK_YEAR 8'hff
`define NVR_TOP_SEC 8'h59
`define NVR_TOP_HOUR 8'h23
`define NVR_TOP_DAY 8'h07
`define NVR_TOP_MON 8'h12
`define NVR_TOP_YEAR 8'h99
`define NVR_TOP_CEN 8'h39
`define NVR_RST_ONE 8'h01
`define NVR_RST_ZERO 8'h00
`endif

// *** shared/nvr_pkg.sv ***
`default_nettype none
package nvr_pkg;
  typedef enum logic [1:0] {mode_off, mode_idle, mode_read, mode_write} nvr_mode_type;
endpackage: nvr_pkg
`default_nettype wire

// *** shared/nvr_tick_if.sv ***
`default_nettype none
interface nvr_tick_if;
  logic run;
  logic restart;
  logic sec_tick;
  logic test_toggle;
  modport src (input run, input restart, output sec_tick, output test_toggle);
  modport snk (output run, output restart, input sec_tick, input test_toggle);
endinterface: nvr_tick_if
`default_nettype wire

// *** logic/nvr_prescaler.sv ***
`include "nvr_params.svh"
`default_nettype none
module nvr_prescaler #(
  parameter int SEC_CYCLES = `NVR_SEC_CYCLES,
  parameter int HALF_CYCLES = `NVR_HALF_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  nvr_tick_if.src tk
);
  logic [24:0] sec_cnt;
  logic [14:0] half_cnt;

  // one-second enable pulse
  always_ff @(posedge clk_i) begin
    if (!resetn_i || tk.restart) begin
      sec_cnt <= 25'h0;
      tk.sec_tick <= 1'b0;
    end else if (tk.run) begin
      if (sec_cnt == 25'(SEC_CYCLES - 1)) begin
        sec_cnt <= 25'h0;
        tk.sec_tick <= 1'b1;
      end else begin
        sec_cnt <= sec_cnt + 25'h1;
        tk.sec_tick <= 1'b0;
      end
    end else begin
      tk.sec_tick <= 1'b0;
    end
  end

  // test square wave, held while stopped
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      half_cnt <= 15'h0;
      tk.test_toggle <= 1'b0;
    end else if (tk.run) begin
      if (half_cnt == 15'(HALF_CYCLES - 1)) begin
        half_cnt <= 15'h0;
        tk.test_toggle <= ~tk.test_toggle;
      end else begin
        half_cnt <= half_cnt + 15'h1;
      end
    end
  end
endmodule: nvr_prescaler
`default_nettype wire

// *** logic/nvr_rtc_top.sv ***
// Summary of operation
// - clock registers occupy the eight top byte addresses, accessed like RAM.
// - century to seconds kept in BCD, hours on a 24-hour scale.
// - month lengths and leap years handled automatically through 2099.
// - internal counters separate from visible registers and keep counting unless the oscillator is stopped.
// - read-hold bit 6 of century byte freezes visible register updates.
// - while held, visible registers show the time captured at hold.
// - after hold release, all visible registers refresh together within a second.
// - write-hold bit 7 of century byte halts updates for loading time.
// - clearing write-hold copies loaded values into counters, then counting resumes.
// - oscillator stop bit 7 of seconds byte stops the clock, writable anytime.
// - frequency test bit 6 of day byte makes seconds LSB toggle 512 Hz.
// - continuous seconds read shows the 512 Hz toggle on data line 0.
// - supply good and select high: deselected, data lines high impedance.
// - select and write strobe low: write, data lines are inputs.
// - select and output enable low, strobe high: drive addressed byte.
// - select low, output enable and strobe high: high impedance, no write.
// - supply below power-fail threshold: ignore accesses, high impedance, no writes; registers keep updating.
// - bits without clock function behave as ordinary read/write memory bits.
// - write starts at later of select or strobe; host holds address stable.
`include "nvr_params.svh"
`default_nettype none
module nvr_rtc_top #(
  parameter int SEC_CYCLES = `NVR_SEC_CYCLES,
  parameter int HALF_CYCLES = `NVR_HALF_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [18:0] addr_i,
  input wire logic [7:0] data_i,
  input wire logic cen_n_i,
  input wire logic oen_n_i,
  input wire logic wen_n_i,
  input wire logic supply_ok_i,
  output logic [7:0] data_o,
  output logic data_oe_n_o
);
  logic [3:0] ctl_s1, ctl_s2, ctl_s3, ctl;
  logic [18:0] addr_s1, addr_s2, addr_s3;
  logic [7:0] data_s1, data_s2, data_s3;
  logic pwr_ok, cen_n, oen_n, wen_n;
  nvr_pkg::nvr_mode_type mode, next_mode;
  logic [18:0] wr_addr;
  logic [7:0] wr_data;
  logic commit, wr_clk, rd_clk, hold, whold_q, load, run, ft;
  logic [2:0] wr_idx;
  logic strobe_s3;
  logic [7:0] rd_byte;
  logic [7:0] vis [0:7];
  logic [7:0] cnt [0:7];
  logic [7:0] next_cnt [0:7];
  logic [7:0] mem [0:524287];
  logic [8:0] step;
  logic carry;
  nvr_tick_if tk ();

  function automatic logic [7:0] field_mask(input logic [2:0] i);
    case (i)
      `NVR_IX_CEN: field_mask = `NVR_MASK_CEN;
      `NVR_IX_SEC: field_mask = `NVR_MASK_SEC;
      `NVR_IX_MIN: field_mask = `NVR_MASK_MIN;
      `NVR_IX_HOUR: field_mask = `NVR_MASK_HOUR;
      `NVR_IX_DAY: field_mask = `NVR_MASK_DAY;
      `NVR_IX_DATE: field_mask = `NVR_MASK_DATE;
      `NVR_IX_MON: field_mask = `NVR_MASK_MON;
      default: field_mask = `NVR_MASK_YEAR;
    endcase
  endfunction: field_mask

  function automatic logic [7:0] rst_val(input logic [2:0] i);
    if (i == `NVR_IX_DAY || i == `NVR_IX_DATE || i == `NVR_IX_MON) begin
      rst_val = `NVR_RST_ONE;
    end else begin
      rst_val = `NVR_RST_ZERO;
    end
  endfunction: rst_val

  // bcd increment with wrap; bit 8 is the carry
  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] top, input logic [7:0] low);
    if (v == top) begin
      bcd_step = {1'b1, low};
    end else if (v[3:0] == 4'h9) begin
      bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_step = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
  endfunction: bcd_step

  // last date of the month, bcd
  function automatic logic [7:0] days_in(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
                   (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    if (mon == 8'h02) begin
      days_in = leap ? 8'h29 : 8'h28;
    end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) begin
      days_in = 8'h30;
    end else begin
      days_in = 8'h31;
    end
  endfunction: days_in

  // true for the eight clock byte addresses
  function automatic logic clk_hit(input logic [18:0] a);
    logic [18:0] base;
    base = `NVR_CLK_BASE;
    clk_hit = (a[18:3] == base[18:3]);
  endfunction: clk_hit

  // pin synchronisers
  always_ff @(posedge clk_i) begin
    ctl_s1 <= {supply_ok_i, cen_n_i, oen_n_i, wen_n_i};
    ctl_s2 <= ctl_s1;
    ctl_s3 <= ctl_s2;
    addr_s1 <= addr_i;
    addr_s2 <= addr_s1;
    addr_s3 <= addr_s2;
    data_s1 <= data_i;
    data_s2 <= data_s1;
    data_s3 <= data_s2;
  end

  // control change accepted once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ctl <= 4'h7;
    end else begin
      ctl <= (ctl & (ctl_s2 ^ ctl_s3)) | (ctl_s3 & ~(ctl_s2 ^ ctl_s3));
    end
  end

  assign pwr_ok = ctl[3];
  assign cen_n = ctl[2];
  assign oen_n = ctl[1];
  assign wen_n = ctl[0];

  // strobe still seen at stage three, aligned with data_s3 and addr_s3
  assign strobe_s3 = !ctl_s3[2] && !ctl_s3[0];

  // access mode decode
  always_comb begin
    if (!pwr_ok) begin
      next_mode = nvr_pkg::mode_off;
    end else if (cen_n) begin
      next_mode = nvr_pkg::mode_idle;
    end else if (!wen_n) begin
      next_mode = nvr_pkg::mode_write;
    end else if (!oen_n) begin
      next_mode = nvr_pkg::mode_read;
    end else begin
      next_mode = nvr_pkg::mode_idle;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      mode <= nvr_pkg::mode_off;
    end else begin
      mode <= next_mode;
    end
  end

  // capture address and data throughout the write
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wr_addr <= 19'h0;
      wr_data <= 8'h00;
    end else if (next_mode == nvr_pkg::mode_write && strobe_s3) begin
      wr_addr <= addr_s3;
      wr_data <= data_s3;
    end
  end

  // write lands at end of the strobe, unless power failed
  assign commit = (mode == nvr_pkg::mode_write) && (next_mode != nvr_pkg::mode_write) &&
                  (next_mode != nvr_pkg::mode_off);
  assign wr_clk = commit && clk_hit(wr_addr);
  assign wr_idx = wr_addr[2:0];
  assign rd_clk = clk_hit(addr_s3);

  always_ff @(posedge clk_i) begin
    if (commit && !wr_clk) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign hold = vis[`NVR_IX_CEN][`NVR_WHOLD_BIT] | vis[`NVR_IX_CEN][`NVR_RHOLD_BIT];
  assign run = ~vis[`NVR_IX_SEC][`NVR_OSC_BIT];
  assign ft = vis[`NVR_IX_DAY][`NVR_FT_BIT];
  assign load = whold_q & ~vis[`NVR_IX_CEN][`NVR_WHOLD_BIT];
  assign tk.run = run;
  assign tk.restart = load;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      whold_q <= 1'b0;
    end else begin
      whold_q <= vis[`NVR_IX_CEN][`NVR_WHOLD_BIT];
    end
  end

  // visible registers: host byte writes, else copy of counters unless held or loading
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 8; i++) begin
        vis[i] <= rst_val(3'(i));
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (wr_clk && wr_idx == 3'(i)) begin
          vis[i] <= wr_data;
        end else if (!hold && !load) begin
          vis[i] <= (vis[i] & ~field_mask(3'(i))) | cnt[i];
        end
      end
    end
  end

  // calendar ripple
  always_comb begin
    next_cnt = cnt;
    step = bcd_step(cnt[`NVR_IX_SEC], `NVR_TOP_SEC, `NVR_RST_ZERO);
    next_cnt[`NVR_IX_SEC] = step[7:0];
    carry = step[8];
    if (carry) begin
      step = bcd_step(cnt[`NVR_IX_MIN], `NVR_TOP_SEC, `NVR_RST_ZERO);
      next_cnt[`NVR_IX_MIN] = step[7:0];
      carry = step[8];
    end
    if (carry) begin
      step = bcd_step(cnt[`NVR_IX_HOUR], `NVR_TOP_HOUR, `NVR_RST_ZERO);
      next_cnt[`NVR_IX_HOUR] = step[7:0];
      carry = step[8];
    end
    if (carry) begin
      step = bcd_step(cnt[`NVR_IX_DAY], `NVR_TOP_DAY, `NVR_RST_ONE);
      next_cnt[`NVR_IX_DAY] = step[7:0];
      step = bcd_step(cnt[`NVR_IX_DATE], days_in(cnt[`NVR_IX_MON], cnt[`NVR_IX_YEAR]), `NVR_RST_ONE);
      next_cnt[`NVR_IX_DATE] = step[7:0];
      carry = step[8];
    end
    if (carry) begin
      step = bcd_step(cnt[`NVR_IX_MON], `NVR_TOP_MON, `NVR_RST_ONE);
      next_cnt[`NVR_IX_MON] = step[7:0];
      carry = step[8];
    end
    if (carry) begin
      step = bcd_step(cnt[`NVR_IX_YEAR], `NVR_TOP_YEAR, `NVR_RST_ZERO);
      next_cnt[`NVR_IX_YEAR] = step[7:0];
      carry = step[8];
    end
    if (carry) begin
      step = bcd_step(cnt[`NVR_IX_CEN], `NVR_TOP_CEN, `NVR_RST_ZERO);
      next_cnt[`NVR_IX_CEN] = step[7:0];
    end
  end

  // internal counters
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 8; i++) begin
        cnt[i] <= rst_val(3'(i));
      end
    end else if (load) begin
      for (int i = 0; i < 8; i++) begin
        cnt[i] <= vis[i] & field_mask(3'(i));
      end
    end else if (tk.sec_tick && run) begin
      cnt <= next_cnt;
    end
  end

  nvr_prescaler #(
    .SEC_CYCLES(SEC_CYCLES),
    .HALF_CYCLES(HALF_CYCLES)
  ) u_prescaler (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .tk(tk.src)
  );

  // read data path
  always_comb begin
    if (rd_clk) begin
      rd_byte = vis[addr_s3[2:0]];
      if (addr_s3[2:0] == `NVR_IX_SEC && ft && run) begin
        rd_byte[0] = tk.test_toggle;
      end
    end else begin
      rd_byte = mem[addr_s3];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      data_o <= 8'h00;
      data_oe_n_o <= 1'b1;
    end else begin
      data_o <= rd_byte;
      data_oe_n_o <= (next_mode != nvr_pkg::mode_read);
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence whold_fall_s;
    vis[`NVR_IX_CEN][`NVR_WHOLD_BIT] ##1 !vis[`NVR_IX_CEN][`NVR_WHOLD_BIT];
  endsequence
  sequence read_req_s;
    pwr_ok && !cen_n && !oen_n && wen_n;
  endsequence

  power_fail_hiz_a: assert property (!pwr_ok |=> data_oe_n_o && !commit)
    else $error("drive or write during power fail");
  deselect_hiz_a: assert property (cen_n |=> data_oe_n_o)
    else $error("drive while deselected");
  write_no_drive_a: assert property (!cen_n && !wen_n |=> data_oe_n_o)
    else $error("drive during write");
  read_drive_a: assert property (read_req_s |=> !data_oe_n_o && data_o == $past(rd_byte))
    else $error("read not driven");
  idle_no_write_a: assert property (commit |-> $past(!cen_n && !wen_n))
    else $error("write without strobe");
  read_hold_a: assert property (vis[`NVR_IX_CEN][`NVR_RHOLD_BIT] && !wr_clk |=> $stable(vis[`NVR_IX_MIN]))
    else $error("visible changed while held");
  refresh_a: assert property (!hold && !wr_clk && !load
    |=> (vis[`NVR_IX_HOUR] & `NVR_MASK_HOUR) == $past(cnt[`NVR_IX_HOUR]))
    else $error("visible not refreshed");
  write_hold_a: assert property (vis[`NVR_IX_CEN][`NVR_WHOLD_BIT] && !wr_clk
    |=> $stable(vis[`NVR_IX_HOUR]))
    else $error("visible changed during write hold");
  write_load_a: assert property (whold_fall_s |=> cnt[`NVR_IX_MIN] == ($past(vis[`NVR_IX_MIN]) & `NVR_MASK_MIN))
    else $error("counters not loaded");
  osc_stop_a: assert property (!run && !load |=> $stable(cnt[`NVR_IX_SEC]))
    else $error("counter moved while stopped");
  sec_wrap_a: assert property (tk.sec_tick && run && !load && cnt[`NVR_IX_SEC] == `NVR_TOP_SEC
    |=> cnt[`NVR_IX_SEC] == `NVR_RST_ZERO)
    else $error("seconds did not wrap");
  test_line_a: assert property (read_req_s && rd_clk && addr_s3[2:0] == `NVR_IX_SEC && ft && run
    |=> data_o[0] == $past(tk.test_toggle))
    else $error("test toggle not on data line 0");
  toggle_stop_a: assert property (!run |=> $stable(tk.test_toggle))
    else $error("test toggle moved while stopped");
endmodule: nvr_rtc_top
`default_nettype wire

// *** tb/nvr_host_model.sv ***
`default_nettype none
module nvr_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_oe_n_i,
  output logic [18:0] addr_o,
  output logic [7:0] data_o,
  output logic cen_n_o,
  output logic oen_n_o,
  output logic wen_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_o = 19'h00000;
    data_o = 8'h00;
    cen_n_o = 1'b1;
    oen_n_o = 1'b1;
    wen_n_o = 1'b1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask: step
  // address and data held for the whole strobe, idle data inverted
  task automatic wr(input logic [18:0] a, input logic [7:0] d);
    addr_o = a;
    data_o = d;
    cen_n_o = 1'b0;
    wen_n_o = 1'b0;
    step(8);
    cen_n_o = 1'b1;
    wen_n_o = 1'b1;
    data_o = ~d;
    step(8);
  endtask: wr
  task automatic rd(input logic [18:0] a, output logic [7:0] d);
    int n;
    addr_o = a;
    cen_n_o = 1'b0;
    oen_n_o = 1'b0;
    n = 0;
    while (rd_oe_n_i !== 1'b0 && n < 20) begin
      step(1);
      n++;
    end
    d = (n < 20) ? rd_data_i : 8'hxx;
    cen_n_o = 1'b1;
    oen_n_o = 1'b1;
    step(8);
  endtask: rd
  // holds select and enable, reports whether the device ever drove
  task automatic probe(input logic [18:0] a, input logic cs, input logic oe, input int n, output logic seen);
    addr_o = a;
    cen_n_o = cs;
    oen_n_o = oe;
    seen = 1'b0;
    repeat (n) begin
      step(1);
      if (rd_oe_n_i !== 1'b1) seen = 1'b1;
    end
    cen_n_o = 1'b1;
    oen_n_o = 1'b1;
    step(8);
  endtask: probe
  // continuous read counting toggles of data line 0
  task automatic scan(input logic [18:0] a, input int n, output int toggles);
    logic prev;
    addr_o = a;
    cen_n_o = 1'b0;
    oen_n_o = 1'b0;
    step(12);
    prev = rd_data_i[0];
    toggles = 0;
    repeat (n) begin
      step(1);
      if (rd_data_i[0] !== prev) toggles++;
      prev = rd_data_i[0];
    end
    cen_n_o = 1'b1;
    oen_n_o = 1'b1;
    step(8);
  endtask: scan
endmodule: nvr_host_model
`default_nettype wire

// *** tb/test_bytewide_nv_rtc_registers.sv ***
`include "nvr_params.svh"
`default_nettype none
module test_bytewide_nv_rtc_registers;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic resetn_i;
  logic supply_ok;
  logic [18:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic cen_n;
  logic oen_n;
  logic wen_n;
  logic oe_n;
  int err_total = 0;
  int check_count = 0;
  always #25 clk_i = ~clk_i;
  nvr_rtc_top #(.SEC_CYCLES(50), .HALF_CYCLES(5)) uut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr),
    .data_i(wdata), .cen_n_i(cen_n), .oen_n_i(oen_n), .wen_n_i(wen_n), .supply_ok_i(supply_ok),
    .data_o(rdata), .data_oe_n_o(oe_n));
  nvr_host_model host (.clk_i(clk_i), .rd_data_i(rdata), .rd_oe_n_i(oe_n), .addr_o(addr), .data_o(wdata),
    .cen_n_o(cen_n), .oen_n_o(oen_n), .wen_n_o(wen_n));
  function automatic logic [18:0] ra(input logic [2:0] ix);
    return `NVR_CLK_BASE + {16'h0000, ix};
  endfunction: ra
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask: give_verdict
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask: chk
  task automatic set_time(input logic [7:0] c, y, m, d, dy, h, mi, s);
    host.wr(ra(`NVR_IX_CEN), 8'h80 | c);
    host.wr(ra(`NVR_IX_YEAR), y);
    host.wr(ra(`NVR_IX_MON), m);
    host.wr(ra(`NVR_IX_DATE), d);
    host.wr(ra(`NVR_IX_DAY), dy);
    host.wr(ra(`NVR_IX_HOUR), h);
    host.wr(ra(`NVR_IX_MIN), mi);
    host.wr(ra(`NVR_IX_SEC), s);
    host.wr(ra(`NVR_IX_CEN), c);
  endtask: set_time
  // one second after 23:59:59, then frozen by the read hold
  task automatic roll(input logic [7:0] c, y, m, d, dy, ec, ey, em, ed, edy);
    logic [7:0] v;
    set_time(c, y, m, d, dy, 8'h23, 8'h59, 8'h59);
    host.step(60);
    host.rd(ra(`NVR_IX_CEN), v);
    chk("century", ec, v);
    host.wr(ra(`NVR_IX_CEN), 8'h40 | ec);
    host.rd(ra(`NVR_IX_CEN), v);
    chk("read hold bit", 8'h40 | ec, v);
    host.rd(ra(`NVR_IX_YEAR), v);
    chk("year", ey, v);
    host.rd(ra(`NVR_IX_MON), v);
    chk("month", em, v);
    host.rd(ra(`NVR_IX_DATE), v);
    chk("date", ed, v);
    host.rd(ra(`NVR_IX_DAY), v);
    chk("day", edy, v);
    host.rd(ra(`NVR_IX_HOUR), v);
    chk("hour", 8'h00, v);
    host.rd(ra(`NVR_IX_MIN), v);
    chk("minute", 8'h00, v);
  endtask: roll
  task automatic t_reset_and_bus;
    logic [7:0] v;
    logic seen;
    host.rd(ra(`NVR_IX_DAY), v);
    chk("reset day", 8'h01, v);
    host.wr(19'h00123, 8'ha5);
    host.rd(19'h00123, v);
    chk("ram byte", 8'ha5, v);
    host.probe(19'h00123, 1'b0, 1'b1, 12, seen);
    chk("select only drive", 8'h00, {7'h00, seen});
    host.probe(19'h00123, 1'b1, 1'b0, 12, seen);
    chk("deselect drive", 8'h00, {7'h00, seen});
    supply_ok = 1'b0;
    host.step(6);
    host.wr(19'h00123, 8'h5a);
    host.probe(19'h00123, 1'b0, 1'b0, 20, seen);
    chk("power fail drive", 8'h00, {7'h00, seen});
    supply_ok = 1'b1;
    host.step(6);
    host.rd(19'h00123, v);
    chk("power fail write", 8'ha5, v);
  endtask: t_reset_and_bus
  task automatic t_hold;
    logic [7:0] s1;
    logic [7:0] s2;
    host.rd(ra(`NVR_IX_SEC), s1);
    host.step(120);
    host.rd(ra(`NVR_IX_SEC), s2);
    chk("held seconds", s1, s2);
    host.wr(ra(`NVR_IX_CEN), 8'h20);
    host.step(2);
    host.rd(ra(`NVR_IX_SEC), s2);
    chk("refresh after hold", 8'h01, {7'h00, s1 !== s2});
  endtask: t_hold
  task automatic t_osc_and_test;
    logic [7:0] v;
    int tg;
    set_time(8'h20, 8'h01, 8'h03, 8'h01, 8'h05, 8'h10, 8'h20, 8'h80);
    host.step(150);
    host.rd(ra(`NVR_IX_SEC), v);
    chk("stopped seconds", 8'h80, v);
    set_time(8'h20, 8'h01, 8'h03, 8'h01, 8'h45, 8'h10, 8'h20, 8'h00);
    host.step(150);
    host.rd(ra(`NVR_IX_SEC), v);
    chk("running seconds", 8'h01, {7'h00, v[7] === 1'b0 && v[6:0] !== 7'h00});
    host.scan(ra(`NVR_IX_SEC), 40, tg);
    chk("test toggles", 8'h01, {7'h00, tg >= 6});
    set_time(8'h20, 8'h01, 8'h03, 8'h01, 8'h85, 8'h10, 8'h20, 8'h00);
    host.rd(ra(`NVR_IX_DAY), v);
    chk("day spare bit", 8'h85, v);
    host.scan(ra(`NVR_IX_SEC), 40, tg);
    chk("no test toggles", 8'h01, {7'h00, tg <= 1});
  endtask: t_osc_and_test
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    give_verdict();
  end
  initial begin
    resetn_i = 1'b0;
    supply_ok = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    resetn_i = 1'b1;
    host.step(6);
    t_reset_and_bus();
    roll(8'h19, 8'h99, 8'h12, 8'h31, 8'h07, 8'h20, 8'h00, 8'h01, 8'h01, 8'h01);
    host.wr(ra(`NVR_IX_CEN), 8'h20);
    roll(8'h20, 8'h04, 8'h02, 8'h28, 8'h03, 8'h20, 8'h04, 8'h02, 8'h29, 8'h04);
    host.wr(ra(`NVR_IX_CEN), 8'h20);
    roll(8'h20, 8'h01, 8'h02, 8'h28, 8'h03, 8'h20, 8'h01, 8'h03, 8'h01, 8'h04);
    t_hold();
    t_osc_and_test();
    give_verdict();
  end
endmodule: test_bytewide_nv_rtc_registers
`default_nettype wire
